/* hdl/wdog_consts.vh */
// Purpose: Shared constants for the watchdog and reset control block.
// Assumes: Included by its bare name from every design file.
// Notes:   Byte offsets are word aligned on a 32-bit AXI4-Lite bus.
`ifndef WDOG_CONSTS_VH
`define WDOG_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_OPT        8'h00
`define OFS_CAUSE      8'h04
`define OFS_IRQ_STAT   8'h08
`define OFS_IRQ_CLR    8'h0c
`define OFS_IRQ_EN     8'h10
`define OFS_CLK_GATE   8'h14
`define OFS_COUNT      8'h18

// ****************************************************************
// Option register fields and reset values
// ****************************************************************
`define OPT_EN_BIT     0
`define OPT_CSEL_BIT   1
`define OPT_PER_LSB    2
`define OPT_PER_MSB    4
`define OPT_EN_RST     1'b1
`define OPT_CSEL_RST   1'b0
`define OPT_PER_RST    3'h0

// ****************************************************************
// Overflow exponents per clock source
// ****************************************************************
`define LFO_EXP_BASE   5'h05
`define LFO_EXP_MAX    5'h0b
`define LFO_CODE_CAP   3'h6
`define BUS_EXP_BASE   5'h0d
`define BUS_CODE_CAP   3'h7
`define CNT_W          20
`define RESUME_TICKS   2'h3

// ****************************************************************
// Reset cause bit positions
// ****************************************************************
`define CAUSE_W        8
`define CAUSE_POR      7
`define CAUSE_LVD      6
`define CAUSE_WDT      5
`define CAUSE_ILLOP    4
`define CAUSE_ILLADR   3

// ****************************************************************
// Interrupt status bits
// ****************************************************************
`define IRQ_W          3
`define IRQ_SERVICE    0
`define IRQ_LOCKWR     1
`define IRQ_RESUME     2

// ****************************************************************
// Clock gates, reset hold and initial values
// ****************************************************************
`define GATE_W         3
`define GATE_RST       3'h7
`define RST_HOLD_CYC   5'h10
`define RESET_VEC_HI   16'hdffe
`define RESET_VEC_LO   16'hdfff
`define SP_RESET       16'h00ff
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

/* hdl/sync3.v */
// Purpose: Three-stage synchroniser for a pin input.
// Assumes: Input may change at any time relative to clk.
// Notes:   Output follows only when the second and third stages agree.
`timescale 1ns/10ps
`include "wdog_consts.vh"

module sync3 (
   // Clock and reset.
   input  wire clk,
   input  wire rst,
   // Pin and filtered level.
   input  wire d,
   output wire q
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   reg out_q;

   // The first stage feeds only the second; the filter compares stages two and three.
   always @(posedge clk) begin
      if (rst) begin
         s1_q  <= 1'b0;
         s2_q  <= 1'b0;
         s3_q  <= 1'b0;
         out_q <= 1'b0;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            out_q <= s3_q;
         end
      end
   end

   assign q = out_q;
endmodule

/* hdl/reset_cause.v */
// Purpose: Reset source collection and the reset cause register.
// Assumes: Source inputs are one-cycle pulses on clk.
// Notes:   Debug-forced and periodic resets reset the system but leave the cause bits.
`timescale 1ns/10ps
`include "wdog_consts.vh"

module reset_cause (
   // Clock and power-on reset.
   input  wire                 clk,
   input  wire                 rst,
   // Reset sources.
   input  wire                 lvd_pulse,
   input  wire                 wdt_pulse,
   input  wire                 illop_pulse,
   input  wire                 illadr_pulse,
   input  wire                 bdm_rst_pulse,
   input  wire                 periodic_pulse,
   // Results.
   output wire                 sys_evt,
   output wire [`CAUSE_W-1:0]  cause,
   output wire                 periodic_reset_flag
);
   reg [`CAUSE_W-1:0] cause_q;
   reg                prf_q;
   wire               rec_evt;

   // Any of the six sources starts a system reset.
   assign rec_evt = lvd_pulse | wdt_pulse | illop_pulse | illadr_pulse;
   assign sys_evt = rec_evt | bdm_rst_pulse | periodic_pulse;

   // Latest recorded source replaces all earlier indications.
   always @(posedge clk) begin
      if (rst) begin
         cause_q                <= {`CAUSE_W{1'b0}};
         cause_q[`CAUSE_POR]    <= 1'b1;
         prf_q                  <= 1'b0;
      end else begin
         if (rec_evt) begin
            cause_q                 <= {`CAUSE_W{1'b0}};
            cause_q[`CAUSE_LVD]     <= lvd_pulse;
            cause_q[`CAUSE_WDT]     <= wdt_pulse;
            cause_q[`CAUSE_ILLOP]   <= illop_pulse;
            cause_q[`CAUSE_ILLADR]  <= illadr_pulse;
         end
         if (sys_evt) begin
            prf_q <= periodic_pulse;
         end
      end
   end

   assign cause               = cause_q;
   assign periodic_reset_flag = prf_q;
endmodule

/* hdl/wdog_reset_ctrl.v */
// Purpose: Watchdog timer, reset sequencing and reset initial conditions.
// Assumes: clk is the CPU bus clock; the low-frequency oscillator arrives as a pin.
// Notes:   Registers are reached over AXI4-Lite with 32-bit data.
`timescale 1ns/10ps
`include "wdog_consts.vh"

module wdog_reset_ctrl (
   // Clock and power-on reset.
   input  wire                clk,
   input  wire                rst,
   // AXI4-Lite write address and data.
   input  wire [7:0]          s_axi_awaddr,
   input  wire                s_axi_awvalid,
   output wire                s_axi_awready,
   input  wire [31:0]         s_axi_wdata,
   input  wire [3:0]          s_axi_wstrb,
   input  wire                s_axi_wvalid,
   output wire                s_axi_wready,
   // AXI4-Lite write response.
   output wire [1:0]          s_axi_bresp,
   output wire                s_axi_bvalid,
   input  wire                s_axi_bready,
   // AXI4-Lite read.
   input  wire [7:0]          s_axi_araddr,
   input  wire                s_axi_arvalid,
   output wire                s_axi_arready,
   output wire [31:0]         s_axi_rdata,
   output wire [1:0]          s_axi_rresp,
   output wire                s_axi_rvalid,
   input  wire                s_axi_rready,
   // Oscillator pin and processor modes.
   input  wire                low_freq_oscillator,
   input  wire                bdm_active,
   input  wire                stop1_mode,
   input  wire                stop4_mode,
   // Other reset sources.
   input  wire                lvd_rst,
   input  wire                illop_rst,
   input  wire                illadr_rst,
   input  wire                bdm_force_rst,
   input  wire                periodic_hw_reset,
   // Reset outputs and initial conditions.
   output wire                sys_rst,
   output wire                vector_load,
   output wire [15:0]         vector_addr_hi,
   output wire [15:0]         vector_addr_lo,
   output wire                int_mask_set,
   output wire [15:0]         stack_pointer_init,
   output wire                periph_disable,
   output wire                pin_hiz_no_pull,
   output wire                periodic_reset_flag,
   // Clock gates and interrupt.
   output wire                low_freq_osc_run,
   output wire [`GATE_W-1:0]  clk_gate_en,
   output wire                irq
);
   // ****************************************************************
   // Declarations
   // ****************************************************************
   reg                 en_q;
   reg                 csel_q;
   reg  [2:0]          per_q;
   reg                 locked_q;
   reg  [`CNT_W-1:0]   cnt_q;
   reg                 stop_prev_q;
   reg                 lfo_prev_q;
   reg                 resume_wait_q;
   reg  [1:0]          resume_cnt_q;
   reg  [4:0]          hold_q;
   reg                 sys_rst_q;
   reg                 vload_q;
   reg  [15:0]         vec_hi_q;
   reg  [15:0]         vec_lo_q;
   reg  [15:0]         sp_q;
   reg  [`IRQ_W-1:0]   irq_stat_q;
   reg  [`IRQ_W-1:0]   irq_en_q;
   reg  [`GATE_W-1:0]  gate_q;
   reg                 irq_q;
   reg                 aw_held_q;
   reg  [7:0]          awaddr_q;
   reg                 w_held_q;
   reg  [31:0]         wdata_q;
   reg  [3:0]          wstrb_q;
   reg                 bvalid_q;
   reg  [1:0]          bresp_q;
   reg                 rvalid_q;
   reg  [31:0]         rdata_q;
   reg  [1:0]          rresp_q;
   reg  [4:0]          exp_w;
   reg  [31:0]         rd_word;
   reg                 rd_ok;
   wire                lfo_s;
   wire                lfo_tick;
   wire                tick;
   wire                stop_any;
   wire                run;
   wire [`CNT_W-1:0]   limit;
   wire                wdt_fire;
   wire                sys_evt;
   wire [`CAUSE_W-1:0] cause;
   wire                wr_go;
   wire                s_axi_wstrb_any;
   wire                wr_opt;
   wire                wr_service;
   wire                wr_lock_ign;
   wire                wr_ok;
   wire                rd_go;

   // ****************************************************************
   // Submodules
   // ****************************************************************

   // Oscillator pin is asynchronous to the bus clock.
   sync3 u_lfo_sync (
      .clk (clk),
      .rst (rst),
      .d   (low_freq_oscillator),
      .q   (lfo_s)
   );

   // Reset sources and cause register.
   reset_cause u_cause (
      .clk                 (clk),
      .rst                 (rst),
      .lvd_pulse           (lvd_rst),
      .wdt_pulse           (wdt_fire),
      .illop_pulse         (illop_rst),
      .illadr_pulse        (illadr_rst),
      .bdm_rst_pulse       (bdm_force_rst),
      .periodic_pulse      (periodic_hw_reset),
      .sys_evt             (sys_evt),
      .cause               (cause),
      .periodic_reset_flag (periodic_reset_flag)
   );

   // ****************************************************************
   // Watchdog clock, limit and run condition
   // ****************************************************************

   // A tick is one rising edge of the selected source.
   assign lfo_tick = lfo_s & ~lfo_prev_q;
   assign tick     = csel_q ? 1'b1 : lfo_tick;
   assign stop_any = stop1_mode | stop4_mode;
   assign run      = en_q & ~bdm_active & ~stop_any & ~resume_wait_q & ~sys_rst_q;

   // Overflow exponent from period code and source.
   always @* begin
      if (csel_q) begin
         exp_w = (per_q == `BUS_CODE_CAP) ? (`BUS_EXP_BASE + 5'h6)
                                          : (`BUS_EXP_BASE + {2'h0, per_q});
      end else begin
         exp_w = (per_q >= `LFO_CODE_CAP) ? `LFO_EXP_MAX
                                          : (`LFO_EXP_BASE + {2'h0, per_q});
      end
   end

   assign limit    = ({{(`CNT_W-1){1'b0}}, 1'b1} << exp_w) - {{(`CNT_W-1){1'b0}}, 1'b1};
   assign wdt_fire = run & tick & (cnt_q == limit);

   // ****************************************************************
   // Watchdog counter and stop-mode resume
   // ****************************************************************

   // Counter clears on reset, service, stop entry and overflow.
   always @(posedge clk) begin
      if (rst | sys_evt) begin
         cnt_q         <= {`CNT_W{1'b0}};
         stop_prev_q   <= 1'b0;
         lfo_prev_q    <= 1'b0;
         resume_wait_q <= 1'b0;
         resume_cnt_q  <= 2'h0;
      end else begin
         stop_prev_q <= stop_any;
         lfo_prev_q  <= lfo_s;
         if (wr_service) begin
            cnt_q <= {`CNT_W{1'b0}};
         end else if (stop_any & ~stop_prev_q & en_q) begin
            cnt_q <= {`CNT_W{1'b0}};
         end else if (run & tick) begin
            cnt_q <= cnt_q + {{(`CNT_W-1){1'b0}}, 1'b1};
         end
         if (~stop_any & stop_prev_q & en_q) begin
            resume_wait_q <= 1'b1;
            resume_cnt_q  <= 2'h0;
         end else if (resume_wait_q & tick) begin
            resume_cnt_q <= resume_cnt_q + 2'h1;
            if (resume_cnt_q == (`RESUME_TICKS - 2'h1)) begin
               resume_wait_q <= 1'b0;
            end
         end
      end
   end

   // ****************************************************************
   // Reset sequencing and initial conditions
   // ****************************************************************

   // Hold the system in reset, then pulse the vector load.
   always @(posedge clk) begin
      if (rst | sys_evt) begin
         hold_q    <= `RST_HOLD_CYC;
         sys_rst_q <= 1'b1;
         vload_q   <= 1'b0;
         vec_hi_q  <= `RESET_VEC_HI;
         vec_lo_q  <= `RESET_VEC_LO;
         sp_q      <= `SP_RESET;
      end else begin
         vload_q <= 1'b0;
         if (hold_q != 5'h00) begin
            hold_q <= hold_q - 5'h01;
            if (hold_q == 5'h01) begin
               sys_rst_q <= 1'b0;
               vload_q   <= 1'b1;
            end
         end
      end
   end

   assign sys_rst            = sys_rst_q;
   assign vector_load        = vload_q;
   assign vector_addr_hi     = vec_hi_q;
   assign vector_addr_lo     = vec_lo_q;
   assign stack_pointer_init = sp_q;
   assign int_mask_set       = sys_rst_q;
   assign periph_disable     = sys_rst_q;
   assign pin_hiz_no_pull    = sys_rst_q;
   assign low_freq_osc_run   = 1'b1;
   assign clk_gate_en        = gate_q;

   // ****************************************************************
   // AXI4-Lite write path
   // ****************************************************************

   // Address and data are held independently until both have arrived.
   assign s_axi_awready = ~aw_held_q & ~bvalid_q;
   assign s_axi_wready  = ~w_held_q & ~bvalid_q;
   assign wr_go         = aw_held_q & w_held_q & ~bvalid_q;
   assign wr_opt        = wr_go & (awaddr_q == `OFS_OPT) & s_axi_wstrb_any;
   assign wr_lock_ign   = wr_opt & locked_q;
   assign wr_service    = wr_go & (awaddr_q == `OFS_CAUSE);
   assign wr_ok         = (awaddr_q == `OFS_OPT) | (awaddr_q == `OFS_CAUSE) |
                          (awaddr_q == `OFS_IRQ_CLR) | (awaddr_q == `OFS_IRQ_EN) |
                          (awaddr_q == `OFS_CLK_GATE);
   assign s_axi_wstrb_any = wstrb_q[0];

   // Channel capture and response.
   always @(posedge clk) begin
      if (rst) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bvalid_q & s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;

   // ****************************************************************
   // Software registers
   // ****************************************************************

   // Write-once option register, gates, enables and sticky status.
   always @(posedge clk) begin
      if (rst | sys_evt) begin
         en_q       <= `OPT_EN_RST;
         csel_q     <= `OPT_CSEL_RST;
         per_q      <= `OPT_PER_RST;
         locked_q   <= 1'b0;
         gate_q     <= `GATE_RST;
         irq_en_q   <= {`IRQ_W{1'b0}};
         irq_stat_q <= {`IRQ_W{1'b0}};
         irq_q      <= 1'b0;
      end else begin
         if (wr_opt & ~locked_q) begin
            en_q     <= wdata_q[`OPT_EN_BIT];
            csel_q   <= wdata_q[`OPT_CSEL_BIT];
            per_q    <= wdata_q[`OPT_PER_MSB:`OPT_PER_LSB];
            locked_q <= 1'b1;
         end
         if (wr_go & (awaddr_q == `OFS_CLK_GATE) & wstrb_q[0]) begin
            gate_q <= wdata_q[`GATE_W-1:0];
         end
         if (wr_go & (awaddr_q == `OFS_IRQ_EN) & wstrb_q[0]) begin
            irq_en_q <= wdata_q[`IRQ_W-1:0];
         end
         // Set beats clear when both land in one cycle.
         irq_stat_q <= (irq_stat_q & ~((wr_go & (awaddr_q == `OFS_IRQ_CLR) & wstrb_q[0]) ?
                                       wdata_q[`IRQ_W-1:0] : {`IRQ_W{1'b0}}))
                       | {resume_wait_q & tick & (resume_cnt_q == (`RESUME_TICKS - 2'h1)),
                          wr_lock_ign, wr_service};
         irq_q <= |(irq_stat_q & irq_en_q);
      end
   end

   assign irq = irq_q;

   // ****************************************************************
   // AXI4-Lite read path
   // ****************************************************************

   // Read mux; unmapped addresses answer zero with an error.
   always @* begin
      rd_word = 32'h0000_0000;
      rd_ok   = 1'b1;
      case (s_axi_araddr)
         `OFS_OPT:      rd_word = {27'h0, per_q, csel_q, en_q};
         `OFS_CAUSE:    rd_word = {24'h0, cause};
         `OFS_IRQ_STAT: rd_word = {29'h0, irq_stat_q};
         `OFS_IRQ_CLR:  rd_word = 32'h0000_0000;
         `OFS_IRQ_EN:   rd_word = {29'h0, irq_en_q};
         `OFS_CLK_GATE: rd_word = {29'h0, gate_q};
         `OFS_COUNT:    rd_word = {12'h0, cnt_q};
         default:       rd_ok   = 1'b0;
      endcase
   end

   assign s_axi_arready = ~rvalid_q;
   assign rd_go         = s_axi_arvalid & ~rvalid_q;

   // One read in flight; data stands until taken.
   always @(posedge clk) begin
      if (rst) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= `RESP_OKAY;
      end else if (rd_go) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_word;
         rresp_q  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_q & s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;
endmodule

/* sim/wdog_chk_asserts.sv */
// Purpose: Port assertions for the watchdog and reset control block.
// Assumes: Bound to every instance of wdog_reset_ctrl.
// Notes:   Only top-level ports are watched.
`timescale 1ns/10ps
module wdog_chk (
   // Watched ports.
   input wire        clk,
   input wire        rst,
   input wire        lvd_rst,
   input wire        periodic_hw_reset,
   input wire        sys_rst,
   input wire        vector_load,
   input wire [15:0] vector_addr_hi,
   input wire [15:0] vector_addr_lo,
   input wire [15:0] stack_pointer_init,
   input wire        int_mask_set,
   input wire        periph_disable,
   input wire        pin_hiz_no_pull,
   input wire        periodic_reset_flag,
   input wire        low_freq_osc_run
);
   // ****************************************************************
   // Reset sequencing checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_boot; $fell(sys_rst) |-> ##[0:1] vector_load; endproperty
   a_boot: assert property (p_boot) else $error("vector load missing");
   property p_pulse; vector_load |=> !vector_load; endproperty
   a_pulse: assert property (p_pulse) else $error("vector load too long");
   property p_vec; vector_load |-> vector_addr_hi == 16'hdffe && vector_addr_lo == 16'hdfff
      && stack_pointer_init == 16'h00ff; endproperty
   a_vec: assert property (p_vec) else $error("bad initial values");
   property p_init; $rose(sys_rst) |-> ##[0:1] (int_mask_set && periph_disable
      && pin_hiz_no_pull); endproperty
   a_init: assert property (p_init) else $error("reset conditions missing");
   property p_lfo; low_freq_osc_run; endproperty
   a_lfo: assert property (p_lfo) else $error("slow oscillator stopped");
   property p_lvd; lvd_rst |-> ##[1:3] sys_rst; endproperty
   a_lvd: assert property (p_lvd) else $error("no reset after low voltage");
   property p_hold; $rose(sys_rst) |-> sys_rst[*8]; endproperty
   a_hold: assert property (p_hold) else $error("reset too short");
   property p_prf; periodic_hw_reset |-> ##[1:3] periodic_reset_flag; endproperty
   a_prf: assert property (p_prf) else $error("periodic flag missing");
   // Main scenarios reached.
   c_boot: cover property (vector_load);
   c_lvd: cover property (lvd_rst);
   c_prf: cover property (periodic_reset_flag);
endmodule
bind wdog_reset_ctrl wdog_chk u_chk (.*);

/* sim/tb_top.sv */
// Purpose: Self-checking bench for the watchdog and reset control block.
// Assumes: Write strobes held constant; one stop-mode pass on the bus clock.
// Notes:   The slow oscillator pin is toggled by the bench.
`timescale 1ns/10ps
`include "wdog_consts.vh"
module tb_top;
   logic        clk = 0, rst = 1, bdm_active = 0, low_freq_oscillator = 0;
   logic        stop1_mode = 0, stop4_mode = 0, s_axi_bready = 0, s_axi_rready = 0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
   logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, d;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [4:0]  src = '0;
   logic [1:0]  r;
   wire         lvd_rst = src[0], illop_rst = src[1], illadr_rst = src[2];
   wire         bdm_force_rst = src[3], periodic_hw_reset = src[4];
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]   s_axi_bresp, s_axi_rresp;
   wire [31:0]  s_axi_rdata;
   wire         sys_rst, vector_load, int_mask_set, periph_disable, pin_hiz_no_pull;
   wire         periodic_reset_flag, low_freq_osc_run, irq;
   wire [15:0]  vector_addr_hi, vector_addr_lo, stack_pointer_init;
   wire [`GATE_W-1:0] clk_gate_en;
   int          err_total = 0, checked = 0, cyc = 0, n;

   wdog_reset_ctrl dut (.*);

   always #5 clk = ~clk;

   // Cuts a hung run short.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      if (err_total == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got, exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s exp %h got %h", nm, exp, got);
      end
   endtask

   // Register write; each channel is released when taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 0;
   endtask

   // Waits for the end of a system reset.
   task automatic boot();
      n = 0;
      while (vector_load !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      chk("boot", n < 200, 1);
   endtask

   // Write-once option, interrupt masking, gates and an unmapped read.
   task automatic t_lock();
      rd(`OFS_OPT);
      chk("opt_rst", d, 32'h1);
      wr(`OFS_OPT, 32'h3);
      wr(`OFS_OPT, 32'h0);
      rd(`OFS_OPT);
      chk("opt_lock", d, 32'h3);
      wr(`OFS_IRQ_EN, 32'h2);
      @(posedge clk);
      chk("irq_on", irq, 1);
      wr(`OFS_IRQ_EN, 32'h0);
      @(posedge clk);
      chk("irq_mask", irq, 0);
      wr(`OFS_IRQ_CLR, 32'h2);
      wr(`OFS_IRQ_EN, 32'h2);
      @(posedge clk);
      chk("irq_clr", irq, 0);
      wr(`OFS_CLK_GATE, 32'h0);
      chk("gate", {low_freq_osc_run, clk_gate_en}, 32'h8);
      rd(8'h1c);
      chk("unmapped", {r, d[29:0]}, {`RESP_SLVERR, 30'h0});
   endtask

   // Debug hold, servicing and a bus-clock timeout at code 0.
   task automatic t_service();
      logic [31:0] c0;
      repeat (4000) @(posedge clk);
      bdm_active <= 1;
      repeat (4) @(posedge clk);
      rd(`OFS_COUNT);
      c0 = d;
      repeat (50) @(posedge clk);
      rd(`OFS_COUNT);
      chk("bdm_hold", d, c0);
      bdm_active <= 0;
      stop4_mode <= 1;
      repeat (10) @(posedge clk);
      rd(`OFS_COUNT);
      chk("stop_clr", d, 0);
      stop4_mode <= 0;
      repeat (8) @(posedge clk);
      rd(`OFS_IRQ_STAT);
      chk("resume", d[2], 1);
      wr(`OFS_CAUSE, 32'hff);
      rd(`OFS_CAUSE);
      chk("cause_ro", d, 32'h80);
      n = 0;
      while (!sys_rst && n < 9000) begin
         @(posedge clk);
         n++;
      end
      chk("timeout", n > 8170 && n < 8195, 1);
      boot();
      rd(`OFS_CAUSE);
      chk("cause_wdt", d, 32'h20);
   endtask

   // Disabled watchdog, then a slow-clock timeout after a new reset.
   task automatic t_lfo();
      wr(`OFS_OPT, 32'h2);
      n = 0;
      repeat (9000) @(posedge clk) n += sys_rst;
      chk("disabled", n, 0);
      rst <= 1;
      repeat (3) @(posedge clk);
      rst <= 0;
      boot();
      n = 0;
      while (!sys_rst && n < 40) begin
         low_freq_oscillator <= 1;
         repeat (10) @(posedge clk);
         low_freq_oscillator <= 0;
         repeat (10) @(posedge clk);
         n++;
      end
      chk("lfo_ticks", n, 32);
      boot();
   endtask

   // Every other reset source and the cause register after each.
   task automatic t_src();
      logic [7:0] exp_c [5] = '{8'h40, 8'h10, 8'h08, 8'h08, 8'h08};
      for (int i = 0; i < 5; i++) begin
         src[i] <= 1;
         @(posedge clk);
         src <= '0;
         boot();
         rd(`OFS_CAUSE);
         chk("cause_src", d, {24'h0, exp_c[i]});
      end
      chk("prf", periodic_reset_flag, 1);
   endtask

   initial begin
      repeat (3) @(posedge clk);
      chk("init", {int_mask_set, periph_disable, pin_hiz_no_pull}, 32'h7);
      rst <= 0;
      boot();
      chk("vec", {vector_addr_hi, vector_addr_lo}, 32'hdffedfff);
      chk("sp", stack_pointer_init, 32'h00ff);
      t_lock();
      t_service();
      t_lfo();
      t_src();
      end_of_test();
   end
endmodule
